// >>> pwm_time_base_consts.svh
// Purpose: offsets, field positions, reset values and counts of the pwm time base
// Assumes: included by bare name
// Notes: definitions only
`ifndef PWM_TIME_BASE_CONSTS_SVH
`define PWM_TIME_BASE_CONSTS_SVH
`define TB_CONTROL_OFFSET 8'h00
`define TB_PERIOD_OFFSET 8'h04
`define TB_COUNT_OFFSET 8'h08
`define TB_STATUS_OFFSET 8'h0c
`define TB_ENABLE_OFFSET 8'h10
`define TB_CLEAR_OFFSET 8'h14
`define TB_ON_BIT 15
`define TB_IDLE_HALT_BIT 13
`define TB_OUT_DIV_HI 7
`define TB_OUT_DIV_LO 4
`define TB_IN_DIV_HI 3
`define TB_IN_DIV_LO 2
`define TB_MODE_HI 1
`define TB_MODE_LO 0
`define TB_CONTROL_MASK 16'ha0ff
`define TB_CONTROL_RESET 16'h0000
`define TB_PERIOD_RESET 15'h00ff
`define TB_EV_PERIOD 0
`define TB_EV_POSTSCALE 1
`define TB_EV_MIDPOINT 2
`define TB_EV_SINGLE_DONE 3
`define TB_EV_COUNT 4
`endif

// >>> pwm_time_base_control.sv
// Purpose: pwm time base with control register, counter, postscaler and events
// Assumes: aclk is the instruction cycle clock; cpu_idle is a level from outside
// Notes: registers reached over axi4-lite, one word per register
//
// Contract
// - time base runs only while timebase_on bit 15 is one.
// - with timebase_idle_halt bit 13 set, time base halts during cpu idle.
// - postscale ratio is one to field value plus one, bits 7 to 4.
// - prescale bits 3 to 2 give 1, 4, 16 or 64 cycles per count.
// - mode 00 is a free-running counter.
// - mode 01 runs one period then stops.
// - mode 10 counts up then down repeatedly.
// - mode 11 counts up and down, raising events twice per period.
// - bits 14 and 12 to 8 read as zero and ignore writes.
//
// Implementation choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "pwm_time_base_consts.svh"
module pwm_time_base_control (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic cpu_idle,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic timebase_event,
  output logic irq
);
  typedef struct packed {
    logic idle_m;
    logic idle_s;
    logic [15:0] control;
    logic [14:0] period;
    logic [14:0] count;
    logic down;
    logic [3:0] post_cnt;
    logic [`TB_EV_COUNT-1:0] status;
    logic [`TB_EV_COUNT-1:0] irq_en;
    logic timebase_event;
    logic irq;
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic awready;
    logic wready;
    logic arready;
  } tb_state_t;
  tb_state_t s;
  tb_state_t next_s;
  logic run;
  logic tick;
  pwm_time_base_pkg::count_mode_t mode;
  logic [`TB_EV_COUNT-1:0] ev;
  logic [15:0] wr16;
  // idle level crosses from the cpu domain, used only after the second stage
  assign run = s.control[`TB_ON_BIT]
    && !(s.control[`TB_IDLE_HALT_BIT] && s.idle_s);
  assign mode = pwm_time_base_pkg::count_mode_t'(s.control[`TB_MODE_HI:`TB_MODE_LO]);
  tb_prescaler u_pre (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(run),
    .sel(pwm_time_base_pkg::in_div_t'(s.control[`TB_IN_DIV_HI:`TB_IN_DIV_LO])),
    .tick(tick)
  );
  always_comb begin
    next_s = s;
    ev = '0;
    wr16 = s.control;
    next_s.idle_m = cpu_idle;
    next_s.idle_s = s.idle_m;
    next_s.timebase_event = 1'b0;
    // counting
    if (!s.control[`TB_ON_BIT]) begin
      next_s.post_cnt = 4'h0;
      next_s.count = 15'h0000;
      next_s.down = 1'b0;
    end else if (tick) begin
      case (mode)
        pwm_time_base_pkg::mode_free_run,
        pwm_time_base_pkg::mode_single: begin
          if (s.count >= s.period) begin
            next_s.count = 15'h0000;
            ev[`TB_EV_PERIOD] = 1'b1;
            if (mode == pwm_time_base_pkg::mode_single) begin
              // one period only: software must set timebase_on again
              next_s.control[`TB_ON_BIT] = 1'b0;
              ev[`TB_EV_SINGLE_DONE] = 1'b1;
            end
          end else begin
            next_s.count = s.count + 15'h0001;
          end
        end
        default: begin
          if (!s.down) begin
            if (s.count >= s.period) begin
              if (mode == pwm_time_base_pkg::mode_up_down_double) begin
                ev[`TB_EV_MIDPOINT] = 1'b1;
              end
              if (s.count <= 15'h0001) begin
                // period of one or zero: the top is the bottom, no wrap below zero
                next_s.count = 15'h0000;
                ev[`TB_EV_PERIOD] = 1'b1;
              end else begin
                next_s.down = 1'b1;
                next_s.count = s.count - 15'h0001;
              end
            end else begin
              next_s.count = s.count + 15'h0001;
            end
          end else if (s.count == 15'h0000 || s.count == 15'h0001) begin
            next_s.count = 15'h0000;
            next_s.down = 1'b0;
            ev[`TB_EV_PERIOD] = 1'b1;
          end else begin
            next_s.count = s.count - 15'h0001;
          end
        end
      endcase
      if (ev[`TB_EV_PERIOD]) begin
        if (s.post_cnt >= s.control[`TB_OUT_DIV_HI:`TB_OUT_DIV_LO]) begin
          next_s.post_cnt = 4'h0;
          ev[`TB_EV_POSTSCALE] = 1'b1;
          next_s.timebase_event = 1'b1;
        end else begin
          next_s.post_cnt = s.post_cnt + 4'h1;
        end
      end
    end
    // axi write
    if (s_axi_awvalid && s_axi_awready) begin
      next_s.aw_held = 1'b1;
      next_s.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_s.w_held = 1'b1;
      next_s.w_data = s_axi_wdata;
      next_s.w_strb = s_axi_wstrb;
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end
    if (s.aw_held && s.w_held && !s.bvalid) begin
      next_s.aw_held = 1'b0;
      next_s.w_held = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = 2'b00;
      if (s.w_strb[0]) begin
        wr16[7:0] = s.w_data[7:0];
      end
      if (s.w_strb[1]) begin
        wr16[15:8] = s.w_data[15:8];
      end
      if (s.aw_addr == `TB_CONTROL_OFFSET) begin
        next_s.control = wr16 & `TB_CONTROL_MASK;
      end else if (s.aw_addr == `TB_PERIOD_OFFSET) begin
        if (s.w_strb[0]) begin
          next_s.period[7:0] = s.w_data[7:0];
        end
        if (s.w_strb[1]) begin
          next_s.period[14:8] = s.w_data[14:8];
        end
      end else if (s.aw_addr == `TB_ENABLE_OFFSET) begin
        if (s.w_strb[0]) begin
          next_s.irq_en = s.w_data[`TB_EV_COUNT-1:0];
        end
      end else if (s.aw_addr == `TB_CLEAR_OFFSET) begin
        if (s.w_strb[0]) begin
          next_s.status = s.status & ~s.w_data[`TB_EV_COUNT-1:0];
        end
      end else if (s.aw_addr != `TB_COUNT_OFFSET && s.aw_addr != `TB_STATUS_OFFSET) begin
        next_s.bresp = 2'b10;
      end
    end
    // set wins over a clear in the same cycle
    next_s.status = next_s.status | ev;
    next_s.irq = |(next_s.status & next_s.irq_en);
    // axi read
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = 2'b00;
      next_s.rdata = 32'h0000_0000;
      if (s_axi_araddr == `TB_CONTROL_OFFSET) begin
        next_s.rdata[15:0] = s.control & `TB_CONTROL_MASK;
      end else if (s_axi_araddr == `TB_PERIOD_OFFSET) begin
        next_s.rdata[14:0] = s.period;
      end else if (s_axi_araddr == `TB_COUNT_OFFSET) begin
        next_s.rdata[14:0] = s.count;
        next_s.rdata[15] = s.down;
      end else if (s_axi_araddr == `TB_STATUS_OFFSET) begin
        next_s.rdata[`TB_EV_COUNT-1:0] = s.status;
      end else if (s_axi_araddr == `TB_ENABLE_OFFSET) begin
        next_s.rdata[`TB_EV_COUNT-1:0] = s.irq_en;
      end else if (s_axi_araddr == `TB_CLEAR_OFFSET) begin
        next_s.rdata = 32'h0000_0000;
      end else begin
        next_s.rresp = 2'b10;
      end
    end
    // readies registered from the next slot state, so they equal the gate they replace
    next_s.awready = !next_s.aw_held && !next_s.bvalid;
    next_s.wready = !next_s.w_held && !next_s.bvalid;
    next_s.arready = !next_s.rvalid;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.control <= `TB_CONTROL_RESET;
      s.period <= `TB_PERIOD_RESET;
      s.awready <= 1'b1;
      s.wready <= 1'b1;
      s.arready <= 1'b1;
    end else begin
      s <= next_s;
    end
  end
  // ready only while the holding slot is free, so one write at a time
  assign s_axi_awready = s.awready;
  assign s_axi_wready = s.wready;
  assign s_axi_arready = s.arready;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
  assign timebase_event = s.timebase_event;
  assign irq = s.irq;
endmodule : pwm_time_base_control

// >>> pwm_time_base_control_assertions.sv
// Purpose: bus handshake and control read checks
// Assumes: bound to the top module, one clock
// Notes: only the read port of control is visible
`timescale 1ns/1ps
`include "pwm_time_base_consts.svh"
module pwm_time_base_control_assertions (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  logic [7:0] raddr;
  // rdata belongs to the address taken last
  always_ff @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready) raddr <= s_axi_araddr;
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("rdata moved");
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp moved");
  a_read_blocks: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("arready during rvalid");
  a_write_blocks: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write ready during bvalid");
  a_bresp_code: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0 || s_axi_bresp == 2'h2)
    else $error("bad bresp");
  a_unmapped_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 0)
    else $error("unmapped data not zero");
  a_ctrl_reserved: assert property (
    s_axi_rvalid && raddr == `TB_CONTROL_OFFSET |-> (s_axi_rdata & ~32'h0000a0ff) == 0)
    else $error("reserved control bits set");
endmodule : pwm_time_base_control_assertions

// >>> pwm_time_base_pkg.sv
// Purpose: types of the pwm time base
// Assumes: nothing
// Notes: constants live in the consts header
package pwm_time_base_pkg;
  typedef enum logic [1:0] {
    mode_free_run = 2'b00,
    mode_single = 2'b01,
    mode_up_down = 2'b10,
    mode_up_down_double = 2'b11
  } count_mode_t;
  typedef enum logic [1:0] {
    in_div_1 = 2'b00,
    in_div_4 = 2'b01,
    in_div_16 = 2'b10,
    in_div_64 = 2'b11
  } in_div_t;
endpackage : pwm_time_base_pkg

// >>> tb_prescaler.sv
// Purpose: input clock prescaler giving one-cycle count enables
// Assumes: aclk is the instruction cycle clock
// Notes: restarts while stopped so the first count after enable is a full tick
`timescale 1ns/1ps
`include "pwm_time_base_consts.svh"
module tb_prescaler (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  input wire pwm_time_base_pkg::in_div_t sel,
  output logic tick
);
  typedef struct packed {
    logic [5:0] cnt;
    logic tick;
  } pre_state_t;
  pre_state_t s;
  pre_state_t next_s;
  logic [5:0] limit;
  always_comb begin
    case (sel)
      pwm_time_base_pkg::in_div_1: limit = 6'h00;
      pwm_time_base_pkg::in_div_4: limit = 6'h03;
      pwm_time_base_pkg::in_div_16: limit = 6'h0f;
      default: limit = 6'h3f;
    endcase
    next_s = s;
    next_s.tick = 1'b0;
    if (!run) begin
      next_s.cnt = 6'h00;
    end else if (s.cnt >= limit) begin
      next_s.cnt = 6'h00;
      next_s.tick = 1'b1;
    end else begin
      next_s.cnt = s.cnt + 6'h01;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
  assign tick = s.tick;
endmodule : tb_prescaler

// >>> test_pwm_time_base_control.sv
// Purpose: random and corner tests of the pwm time base
// Assumes: 40 MHz aclk, synchronous active-low reset
// Notes: short periods keep the run brief
`timescale 1ns/1ps
`include "pwm_time_base_consts.svh"
module test_pwm_time_base_control;
  logic aclk = 0, aresetn = 0, cpu_idle = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic timebase_event, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  int error_cnt = 0, n_checks = 0, p, d, o, n, md;
  pwm_time_base_control pwm_time_base_control_inst (
    .aclk(aclk),
    .aresetn(aresetn),
    .cpu_idle(cpu_idle),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .timebase_event(timebase_event),
    .irq(irq)
  );
  always #12.5 aclk = ~aclk;
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %0t %s got %h want %h", $time, m, g, e);
    end
  endtask : chk
  task automatic lim(input int i);
    if (i >= 20000) begin
      chk(0, 1, "timeout");
      stop_test();
    end
  endtask : lim
  task automatic cyc(input int k);
    repeat (k) @(posedge aclk);
  endtask : cyc
  // response ready comes late on purpose, so the slave must hold it
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int i;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    for (i = 0; i < 20000; i++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_bvalid) break;
    end
    lim(i);
    s_axi_bready <= 1;
    @(posedge aclk);
    rs = s_axi_bresp;
    s_axi_bready <= 0;
  endtask : wr
  task automatic rdr(input logic [7:0] a);
    int i;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    for (i = 0; i < 20000; i++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
      if (s_axi_rvalid) break;
    end
    lim(i);
    s_axi_rready <= 1;
    @(posedge aclk);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 0;
  endtask : rdr
  task automatic gap(output int g);
    int i;
    for (i = 0; i < 20000 && timebase_event !== 1'b1; i++) @(posedge aclk);
    lim(i);
    g = 0;
    do begin
      @(posedge aclk);
      g++;
    end while (timebase_event !== 1'b1 && g < 20000);
    lim(g);
  endtask : gap
  // up/down period is twice the period value, free run one more
  function automatic int exp_gap(int m, int pr, int dv, int os);
    return (m > 1 ? 2 * pr : pr + 1) * (1 << (2 * dv)) * (os + 1);
  endfunction : exp_gap
  initial begin
    void'($urandom(70));
    cyc(6);
    aresetn <= 1;
    cyc(1);
    rdr(`TB_CONTROL_OFFSET);
    chk(rd, 0, "control reset");
    wr(`TB_CONTROL_OFFSET, 32'hffff5fff);
    rdr(`TB_CONTROL_OFFSET);
    chk(rd, 32'h00ff, "reserved bits");
    wr(`TB_CONTROL_OFFSET, 0);
    rdr(8'h18);
    chk(rs, 2'h2, "unmapped read resp");
    chk(rd, 0, "unmapped read data");
    wr(8'h18, 32'h1);
    chk(rs, 2'h2, "unmapped write resp");
    $display("test bus done");
    for (int m = 0; m < 3; m++) begin
      md = m ? m + 1 : 0;
      for (d = 0; d < 4; d++) begin
        o = $urandom % 16;
        p = 1 + $urandom % 2;
        wr(`TB_CONTROL_OFFSET, 0);
        wr(`TB_PERIOD_OFFSET, p);
        wr(`TB_CONTROL_OFFSET, 32'h8000 | o << 4 | d << 2 | md);
        gap(n);
        chk(n, exp_gap(md, p, d, o), "event spacing");
      end
    end
    $display("test spacing done");
    wr(`TB_CONTROL_OFFSET, 0);
    wr(`TB_CLEAR_OFFSET, 32'hf);
    wr(`TB_ENABLE_OFFSET, 0);
    wr(`TB_CONTROL_OFFSET, 32'h8001);
    cyc(30);
    rdr(`TB_CONTROL_OFFSET);
    chk(rd, 32'h1, "single stop");
    rdr(`TB_STATUS_OFFSET);
    chk(rd & 32'h8, 32'h8, "single done");
    wr(`TB_CLEAR_OFFSET, 32'hf);
    wr(`TB_PERIOD_OFFSET, 3);
    wr(`TB_CONTROL_OFFSET, 32'h8003);
    cyc(40);
    wr(`TB_CONTROL_OFFSET, 32'h3);
    rdr(`TB_STATUS_OFFSET);
    chk(rd, 32'h7, "double update status");
    chk(irq, 0, "masked irq");
    wr(`TB_ENABLE_OFFSET, 32'h4);
    cyc(3);
    chk(irq, 1, "irq raised");
    wr(`TB_CLEAR_OFFSET, 32'h4);
    cyc(3);
    chk(irq, 0, "irq cleared");
    wr(`TB_CLEAR_OFFSET, 32'hf);
    wr(`TB_CONTROL_OFFSET, 32'h8002);
    cyc(40);
    wr(`TB_CONTROL_OFFSET, 32'h2);
    rdr(`TB_STATUS_OFFSET);
    chk(rd, 32'h3, "up down status");
    $display("test status done");
    wr(`TB_PERIOD_OFFSET, 32'h7fff);
    wr(`TB_CONTROL_OFFSET, 32'ha000);
    cpu_idle <= 1;
    cyc(5);
    rdr(`TB_COUNT_OFFSET);
    n = rd;
    cyc(10);
    rdr(`TB_COUNT_OFFSET);
    chk(rd, n, "idle halt");
    wr(`TB_CONTROL_OFFSET, 32'h8000);
    rdr(`TB_COUNT_OFFSET);
    n = rd;
    cyc(10);
    rdr(`TB_COUNT_OFFSET);
    chk(rd !== n, 1, "idle run");
    wr(`TB_CONTROL_OFFSET, 0);
    cyc(10);
    rdr(`TB_COUNT_OFFSET);
    chk(rd, 0, "off holds");
    $display("test idle done");
    stop_test();
  end
endmodule : test_pwm_time_base_control
bind pwm_time_base_control pwm_time_base_control_assertions
  pwm_time_base_control_assertions_inst (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awready(s_axi_awready),
    .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready)
  );
